/* File: hdl/sxp_map.vh */
/*
  Constants for the serial I/O expander port logic: bus address, command
  codes, port counts and synchroniser depth.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef SXP_MAP_VH
`define SXP_MAP_VH

// ----------------------------------------
// Bus address
// ----------------------------------------
`define SXP_ADDR_FIXED 5'h16

// ----------------------------------------
// Command codes
// ----------------------------------------
`define SXP_CMD_IN_A 3'h0
`define SXP_CMD_IN_B 3'h1
`define SXP_CMD_OUT_A 3'h2
`define SXP_CMD_OUT_B 3'h3
`define SXP_CMD_DIR_A 3'h4
`define SXP_CMD_DIR_B 3'h5
`define SXP_CMD_MSK_A 3'h6
`define SXP_CMD_MSK_B 3'h7

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define SXP_DIR_RESET 8'h00
`define SXP_MSK_RESET 8'h00
`define SXP_GROUP_W 8
`define SXP_SYNC_DEPTH 3

`endif

/* File: hdl/sxp_sync.v */
/*
  Three-stage synchroniser with agreement filter for pins from outside
  the clock domain.
  Assumes clk is the block clock and rst_n is already synchronous.
*/
module sxp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Raw and filtered level
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // Stage one feeds stage two only; output moves when two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & dout);
    end
  end

endmodule

/* File: hdl/sxp_port.v */
/*
  Serial bus slave, registers and transition detection of a 16-port
  expander. Group A is the drain group, group B the push-pull group.
  Assumes an external master that drives scl and the pull-ups that the
  testbench resolves from the enables; scl is far slower than clk.
*/
`include "sxp_map.vh"

module sxp_port #(
  parameter [7:0] OUT_A_RESET = 8'hff,
  parameter [7:0] OUT_B_RESET = 8'hff
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Serial bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire bus_abort_n,
  // Address select
  input wire addr_select_lo,
  input wire addr_select_hi,
  // Drain port group A
  input wire [7:0] drain_port_group_in,
  output wire [7:0] drain_port_group_out,
  output wire [7:0] drain_port_group_oe,
  // Push-pull port group B
  input wire [7:0] push_pull_port_group_in,
  output wire [7:0] push_pull_port_group_out,
  output wire [7:0] push_pull_port_group_oe,
  // Alert, open drain
  output wire change_alert_n_out,
  output wire change_alert_n_oe
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_m;
  reg rst_n;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire scl;
  wire sda;
  wire abort_n;
  wire [1:0] sel;
  wire [15:0] pins;
  sxp_sync #(.W(3), .INIT(3'h7)) u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .din({scl_in, sda_in, bus_abort_n}),
    .dout({scl, sda, abort_n})
  );
  sxp_sync #(.W(18), .INIT(18'h00000)) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .din({addr_select_hi, addr_select_lo, push_pull_port_group_in, drain_port_group_in}),
    .dout({sel, pins})
  );

  reg scl_d;
  reg sda_d;
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] out_a;
  reg [7:0] out_b;
  reg [7:0] port_direction_config_a;
  reg [7:0] port_direction_config_b;
  reg [7:0] port_change_irq_mask_a;
  reg [7:0] port_change_irq_mask_b;
  reg [2:0] cmd;

  // Read multiplexer, shared by the address-ack load and the repeat-read path that resends the same register
  function [7:0] rd_sel;
    input [2:0] c;
    input [15:0] snap;
    begin
      case (c)
        `SXP_CMD_IN_A: rd_sel = snap[7:0];
        `SXP_CMD_IN_B: rd_sel = snap[15:8];
        `SXP_CMD_OUT_A: rd_sel = out_a;
        `SXP_CMD_OUT_B: rd_sel = out_b;
        `SXP_CMD_DIR_A: rd_sel = port_direction_config_a;
        `SXP_CMD_DIR_B: rd_sel = port_direction_config_b;
        `SXP_CMD_MSK_A: rd_sel = port_change_irq_mask_a;
        default: rd_sel = port_change_irq_mask_b;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_RD = 3'h4;
  localparam ST_RACK = 3'h5;

  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shift;
  reg [7:0] txd;
  reg is_read;
  reg first_data;
  reg ack_drive;
  reg tx_drive;
  reg [15:0] snap;
  reg [1:0] read_grp;
  reg [1:0] ack_grp;

  wire addr_match = (shift[7:3] == `SXP_ADDR_FIXED) && (shift[2:1] == sel);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      txd <= 8'h00;
      is_read <= 1'b0;
      first_data <= 1'b0;
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      cmd <= 3'h0;
      snap <= 16'h0000;
      read_grp <= 2'h0;
      ack_grp <= 2'h0;
      out_a <= 8'h00;
      out_b <= 8'h00;
      port_direction_config_a <= `SXP_DIR_RESET;
      port_direction_config_b <= `SXP_DIR_RESET;
      port_change_irq_mask_a <= `SXP_MSK_RESET;
      port_change_irq_mask_b <= `SXP_MSK_RESET;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      ack_grp <= 2'h0;
      if (state == ST_IDLE && bitcnt == 4'hf) begin
        // Idle with the bit count at 15 clears the count; no outputs are loaded
        bitcnt <= 4'h0;
      end
      if (!abort_n) begin
        // Abort forces the stop condition without touching the alert
        state <= ST_IDLE;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        read_grp <= 2'h0;
      end else if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        read_grp <= 2'h0;
      end else begin
        case (state)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              if (state == ST_WR || addr_match) begin
                ack_drive <= 1'b1;
                state <= ST_ACK;
                if (state == ST_ADDR) begin
                  is_read <= shift[0];
                  first_data <= ~shift[0];
                  if (shift[0]) begin
                    snap <= pins;
                    txd <= rd_sel(cmd, pins);
                    // Alert released and detection rearmed per group
                    read_grp <= {cmd == `SXP_CMD_IN_B, cmd == `SXP_CMD_IN_A};
                    ack_grp <= {cmd == `SXP_CMD_IN_B, cmd == `SXP_CMD_IN_A};
                  end
                end else if (first_data) begin
                  cmd <= shift[2:0];
                  first_data <= 1'b0;
                end else begin
                  // Data bytes after the command go to the register it names; the input registers drop them
                  case (cmd)
                    `SXP_CMD_OUT_A: out_a <= shift;
                    `SXP_CMD_OUT_B: out_b <= shift;
                    `SXP_CMD_DIR_A: port_direction_config_a <= shift;
                    `SXP_CMD_DIR_B: port_direction_config_b <= shift;
                    `SXP_CMD_MSK_A: port_change_irq_mask_a <= shift;
                    `SXP_CMD_MSK_B: port_change_irq_mask_b <= shift;
                    default: ;
                  endcase
                end
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // Hold low across the ninth high phase, release on its fall
            if (scl_fall) begin
              ack_drive <= 1'b0;
              bitcnt <= 4'h0;
              if (is_read) begin
                state <= ST_RD;
                tx_drive <= ~txd[7];
                shift <= {txd[6:0], 1'b0};
                bitcnt <= 4'h1;
              end else begin
                state <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                tx_drive <= 1'b0;
                state <= ST_RACK;
              end else begin
                tx_drive <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Master ack continues, nack ends the read
            if (scl_rise) begin
              if (sda) begin
                state <= ST_IDLE;
              end else begin
                txd <= rd_sel(cmd, snap);
              end
            end
            if (scl_fall && state == ST_RACK) begin
              tx_drive <= ~txd[7];
              shift <= {txd[6:0], 1'b0};
              bitcnt <= 4'h1;
              state <= ST_RD;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = ack_drive | tx_drive;

  // ----------------------------------------
  // Port drive
  // ----------------------------------------
  // Drain group only pulls low; push-pull drives both levels
  assign drain_port_group_out = 8'h00;
  assign drain_port_group_oe = ~port_direction_config_a & ~out_a;
  assign push_pull_port_group_out = out_b;
  assign push_pull_port_group_oe = ~port_direction_config_b;

  // ----------------------------------------
  // Transition detection
  // ----------------------------------------
  reg [15:0] ref_val;
  reg [15:0] flag;
  wire [15:0] is_in = {port_direction_config_b, port_direction_config_a};
  wire [15:0] en = is_in & ~{port_change_irq_mask_b, port_change_irq_mask_a};
  wire [15:0] grp_clr = {{8{ack_grp[1]}}, {8{ack_grp[0]}}};
  // Snapshot taken at the read address ack is the live pin image
  wire [15:0] snap_next = pins;

  // Reference is the live pin image on the clear cycle, so later changes still flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_val <= 16'h0000;
      flag <= 16'h0000;
    end else begin
      // Disabled bits track the pins so enabling them raises no false flag
      ref_val <= (grp_clr & snap_next) | (~grp_clr & ((~en & pins) | (en & ref_val)));
      // Clear beats set; outputs never flag since they are not enabled
      flag <= (flag & ~grp_clr) | (en & (pins ^ ref_val) & ~grp_clr) | (en & (pins ^ snap_next) & grp_clr);
    end
  end
  assign change_alert_n_out = 1'b0;
  assign change_alert_n_oe = |flag;

endmodule

/* File: tb/sxp_port_props.sv */
/* Pin checker for sxp_port.
   Assumes a bind to sxp_port and a single clock domain. */
module sxp_port_props (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bus
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire bus_abort_n,
  // Ports and alert
  input wire [7:0] drain_port_group_in,
  input wire [7:0] drain_port_group_out,
  input wire [7:0] drain_port_group_oe,
  input wire [7:0] push_pull_port_group_in,
  input wire [7:0] push_pull_port_group_oe,
  input wire change_alert_n_out,
  input wire change_alert_n_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----
  // Ages
  // ----
  // Saturating: cycles since reset, since a pin moved or sda_oe was high
  logic [3:0] age;
  logic [3:0] quiet;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age <= 4'h0;
      quiet <= 4'h0;
    end else begin
      age <= age + {3'h0, age != 4'hf};
      quiet <= ($changed({drain_port_group_in, push_pull_port_group_in}) || sda_oe) ? 4'h0
        : quiet + {3'h0, quiet != 4'hf};
    end
  end
  // ----
  // Properties
  // ----
  chk_sda_only_low: assert property (!sda_out) else $error("data line driven high");
  chk_alert_only_low: assert property (!change_alert_n_out) else $error("alert driven high");
  chk_drain_only_low: assert property (drain_port_group_out == 8'h00) else $error("drain driven high");
  chk_ack_scl_low: assert property ($changed(sda_oe) && bus_abort_n |-> !scl_in)
    else $error("data drive moved with clock high");
  chk_ack_held_high: assert property (scl_in [*3] |-> $stable(sda_oe) || !bus_abort_n)
    else $error("data drive unstable in clock high");
  chk_alert_clear_ack: assert property ($fell(change_alert_n_oe) |-> ##[0:3] sda_oe)
    else $error("alert released outside an ack");
  chk_alert_has_cause: assert property ($rose(change_alert_n_oe) |-> quiet != 4'hf)
    else $error("alert without pin change");
  chk_oe_on_write: assert property ($changed({drain_port_group_oe, push_pull_port_group_oe}) && age == 4'hf
    |-> sda_oe || $past(sda_oe) || $past(sda_oe, 2)) else $error("port enable moved outside a write");
  // Main scenarios reached
  cover property ($rose(change_alert_n_oe));
  cover property ($fell(change_alert_n_oe));
  cover property ($changed(push_pull_port_group_oe));
endmodule

bind sxp_port sxp_port_props sxp_port_props_i (
  .clk, .arst_n, .scl_in, .sda_out, .sda_oe, .bus_abort_n,
  .drain_port_group_in, .drain_port_group_out, .drain_port_group_oe,
  .push_pull_port_group_in, .push_pull_port_group_oe, .change_alert_n_out, .change_alert_n_oe
);

/* File: tb/sxp_master.sv */
/* Serial bus master model, 64 ns bit clock.
   Assumes the bench resolves both lines with pull-ups. */
module sxp_master (
  // Pulls on the open-drain lines
  output logic scl_low,
  output logic sda_low,
  // Resolved data line
  input wire sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both released: the clock stands high between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Data moves only in the low phase
  task automatic bit_io(input logic b, output logic r);
    #16 sda_low = !b;
    #16 scl_low = 1'b0;
    #16 r = sda;
    #16 scl_low = 1'b1;
  endtask
  // Start, also usable as a restart
  task automatic start_c;
    #16 sda_low = 1'b0;
    #16 scl_low = 1'b0;
    #16 sda_low = 1'b1;
    #16 scl_low = 1'b1;
  endtask
  task automatic stop_c;
    #16 sda_low = 1'b1;
    #16 scl_low = 1'b0;
    #16 sda_low = 1'b0;
    #16;
  endtask
  // Eight bits MSB first, ninth clock always ours
  task automatic byte_io(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(m, a);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic n);
    logic [7:0] r;
    logic n0, n1, n2;
    start_c;
    byte_io({a, 1'b0}, 1'b1, r, n0);
    byte_io(c, 1'b1, r, n1);
    byte_io(d, 1'b1, r, n2);
    stop_c;
    n = n0 | n1 | n2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] v, output logic n);
    logic [7:0] r;
    logic n0, n1, n2, x;
    start_c;
    byte_io({a, 1'b0}, 1'b1, r, n0);
    byte_io(c, 1'b1, r, n1);
    start_c;
    byte_io({a, 1'b1}, 1'b1, r, n2);
    byte_io(8'hff, 1'b1, v, x);
    stop_c;
    n = n0 | n1 | n2;
  endtask
endmodule

/* File: tb/testbench.sv */
/* Bench for sxp_port with a register model.
   Assumes sxp_master and the bound checker. */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic abort_n = 1'b1;
  logic [1:0] sel = 2'b10;
  logic [7:0] ext_a = 8'hff;
  logic [7:0] ext_b = 8'h3c;
  logic [7:0] rg [8];
  int n_mismatch = 0;
  int checks_done = 0;
  wire scl_low, sda_low, sda_oe, sda_out, al_oe;
  wire [7:0] a_out, a_oe, b_out, b_oe;
  // Pull-up on data; pins resolved from both sides
  wire sda = !(sda_low || sda_oe);
  wire [7:0] pin_a = ext_a & ~a_oe;
  wire [7:0] pin_b = (b_oe & b_out) | (~b_oe & ext_b);
  always #2.5 clk = ~clk;
  sxp_master sxp_master_i (.scl_low(scl_low), .sda_low(sda_low), .sda(sda));
  sxp_port sxp_port_i (
    .clk(clk), .arst_n(arst_n), .scl_in(!scl_low), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_abort_n(abort_n), .addr_select_lo(sel[0]), .addr_select_hi(sel[1]),
    .drain_port_group_in(pin_a), .drain_port_group_out(a_out), .drain_port_group_oe(a_oe),
    .push_pull_port_group_in(pin_b), .push_pull_port_group_out(b_out), .push_pull_port_group_oe(b_oe),
    .change_alert_n_out(), .change_alert_n_oe(al_oe)
  );
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Model view of a register; inputs see pins as resolved
  function automatic logic [7:0] ex(input int c);
    if (c == 0) return ext_a & (rg[4] | rg[2]);
    if (c == 1) return (rg[5] & ext_b) | (~rg[5] & rg[3]);
    return rg[c];
  endfunction
  task automatic w(input int c, input logic [7:0] d);
    logic n;
    sxp_master_i.wr({5'h16, sel}, 8'(c), d, n);
    chk("write ack", 8'h00, {7'h0, n});
    if (c > 1) rg[c] = d;
  endtask
  task automatic r(input int c);
    logic n;
    logic [7:0] v;
    sxp_master_i.rd({5'h16, sel}, 8'(c), v, n);
    chk("read ack", 8'h00, {7'h0, n});
    chk("read data", ex(c), v);
  endtask
  // Alert sampled once synchroniser latency is spent
  task automatic alert(input logic e);
    repeat (20) @(posedge clk);
    #1;
    chk("alert", {7'h0, e}, {7'h0, al_oe});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    // About 30 transfers of a few microseconds each, with wide margin
    #200us;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    int seed;
    logic n;
    seed = $urandom(32'hcc0a);
    foreach (rg[i]) rg[i] = 8'h00;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk);
    for (int c = 2; c < 8; c++) begin
      w(c, 8'($urandom));
      r(c);
    end
    chk("dir b", ~rg[5], b_oe);
    chk("dir a", ~(rg[4] | rg[2]), a_oe);
    $display("done: registers");
    w(0, 8'h5a);
    w(1, 8'ha5);
    for (int c = 0; c < 8; c++) r(c);
    $display("done: read-only");
    sxp_master_i.wr({5'h16, ~sel}, 8'h02, 8'h00, n);
    chk("foreign nack", 8'h01, {7'h0, n});
    r(2);
    $display("done: address");
    w(6, 8'h00);
    w(7, 8'h00);
    w(5, 8'h00);
    w(4, 8'hff);
    r(0);
    r(1);
    alert(1'b0);
    w(3, ~rg[3]);
    alert(1'b0);
    @(posedge clk);
    #1 ext_a = ext_a ^ 8'h01;
    alert(1'b1);
    r(1);
    alert(1'b1);
    r(0);
    alert(1'b0);
    w(6, 8'hff);
    @(posedge clk);
    #1 ext_a = ext_a ^ 8'h02;
    alert(1'b0);
    $display("done: alert");
    report_and_stop;
  end
endmodule
